// >>> logic/bac_pkg.sv
// Purpose: constants for the bus area control register block
// Assumes: one 16-bit register at offset 0 of a small local register port
// Notes: field positions and decode values shared by the top and the decoder
// How it works
// - area control register is 16-bit read/write, cleared to zero at power-on reset
// - manual reset and standby leave the register contents untouched
// - bits 15 to 13 are reserved, read-only, always read zero
// - strobe drive bit 0 floats RAS/CAS in standby and release; 1 drives them
// - byte order flag captures the mode pin on the first clock after power-on reset; writes ignored
// - byte order flag 0 means big-endian, 1 little-endian, for all spaces
// - area 0 burst field: 00 ordinary, 01/10/11 burst ROM of 4/8/16
// - area 5 burst field bits 8:7 select ordinary or burst of 4/8/16
// - area 6 burst field bits 6:5 select ordinary or burst of 4/8/16
// - memory type 000 both normal, 100 area 3 DRAM, 101 both DRAM
// - bit 1 makes area 5 card space instead of normal memory
// - bit 0 makes area 6 card space instead of normal memory
package bac_pkg;
    localparam int unsigned BAC_ADDR_W = 4;
    localparam logic [3:0] BAC_OFS_CTRL_ONE = 4'h0;
    localparam logic [15:0] BAC_CTRL_ONE_RST = 16'h0000;
    localparam logic [15:0] BAC_WR_MASK = 16'h17ff;
    localparam int unsigned BAC_BIT_STROBE = 12;
    localparam int unsigned BAC_BIT_ENDIAN = 11;
    localparam int unsigned BAC_A0_BST_LO = 9;
    localparam int unsigned BAC_A5_BST_LO = 7;
    localparam int unsigned BAC_A6_BST_LO = 5;
    localparam int unsigned BAC_MEMTYPE_LO = 2;
    localparam int unsigned BAC_BIT_A5_CARD = 1;
    localparam int unsigned BAC_BIT_A6_CARD = 0;
    localparam logic [2:0] BAC_MT_NORMAL = 3'h0;
    localparam logic [2:0] BAC_MT_A3_DRAM = 3'h4;
    localparam logic [2:0] BAC_MT_BOTH_DRAM = 3'h5;
    localparam logic [4:0] BAC_BURST_NONE = 5'h00;
    localparam logic [4:0] BAC_BURST_4 = 5'h04;
    localparam logic [4:0] BAC_BURST_8 = 5'h08;
    localparam logic [4:0] BAC_BURST_16 = 5'h10;
endpackage : bac_pkg

// >>> logic/bac_burst_dec.sv
// Purpose: turn a two-bit burst field into a burst enable and beat count
// Assumes: field code 00 means ordinary single access
// Notes: purely combinational
`timescale 1ns/100ps
module bac_burst_dec (
    // field in
    input wire logic [1:0] code,
    // decoded
    output logic burst_en,
    output logic [4:0] beats
);
    import bac_pkg::*;
    always_comb begin
        burst_en = (code != 2'h0);
        case (code)
            2'h1: beats = BAC_BURST_4;
            2'h2: beats = BAC_BURST_8;
            2'h3: beats = BAC_BURST_16;
            default: beats = BAC_BURST_NONE;
        endcase
    end
endmodule : bac_burst_dec

// >>> logic/bac_top.sv
// Purpose: bus area control register and its decoded area settings
// Assumes: rst_n is the power-on reset; manual reset and standby are plain inputs
// Notes: decoded outputs are registered, so they follow a write by one cycle
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module bac_top (
    // clock and power-on reset
    input wire logic mclk,
    input wire logic rst_n,
    // mode strap and system state
    input wire logic byte_order_mode_pin,
    input wire logic manual_reset,
    input wire logic standby,
    input wire logic bus_release,
    // register port
    input wire logic [bac_pkg::BAC_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // decoded settings for the bus cycle generators
    output logic little_endian,
    output logic strobe_float,
    output logic area0_burst_en,
    output logic [4:0] area0_burst_beats,
    output logic area5_burst_en,
    output logic [4:0] area5_burst_beats,
    output logic area6_burst_en,
    output logic [4:0] area6_burst_beats,
    output logic area2_dram,
    output logic area3_dram,
    output logic area5_card_space,
    output logic area6_card_space
);
    import bac_pkg::*;

    typedef struct packed {
        logic strap_pending;
        logic [15:0] ctrl_one;
        logic [15:0] rdata;
        logic little_endian;
        logic strobe_float;
        logic a0_en;
        logic [4:0] a0_beats;
        logic a5_en;
        logic [4:0] a5_beats;
        logic a6_en;
        logic [4:0] a6_beats;
        logic a2_dram;
        logic a3_dram;
        logic a5_card;
        logic a6_card;
    } bac_state_s;

    bac_state_s st_ff;
    bac_state_s nxt_st;
    logic a0_en_d, a5_en_d, a6_en_d;
    logic [4:0] a0_beats_d, a5_beats_d, a6_beats_d;
    logic [2:0] memtype;

    bac_burst_dec u_a0 (
        .code(nxt_st.ctrl_one[BAC_A0_BST_LO +: 2]),
        .burst_en(a0_en_d),
        .beats(a0_beats_d)
    );
    bac_burst_dec u_a5 (
        .code(nxt_st.ctrl_one[BAC_A5_BST_LO +: 2]),
        .burst_en(a5_en_d),
        .beats(a5_beats_d)
    );
    bac_burst_dec u_a6 (
        .code(nxt_st.ctrl_one[BAC_A6_BST_LO +: 2]),
        .burst_en(a6_en_d),
        .beats(a6_beats_d)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = 16'h0000;
        // strap caught on the first edge after power-on release, not in reset
        if (st_ff.strap_pending) begin
            nxt_st.strap_pending = 1'b0;
            nxt_st.ctrl_one[BAC_BIT_ENDIAN] = byte_order_mode_pin;
        end
        // manual_reset and standby deliberately do not touch the register
        if (reg_wr && reg_addr == BAC_OFS_CTRL_ONE) begin
            nxt_st.ctrl_one = (reg_wdata & BAC_WR_MASK)
                | (nxt_st.ctrl_one & ~BAC_WR_MASK);
        end
        if (reg_rd && reg_addr == BAC_OFS_CTRL_ONE) begin
            nxt_st.rdata = st_ff.ctrl_one;
        end
        memtype = nxt_st.ctrl_one[BAC_MEMTYPE_LO +: 3];
        nxt_st.little_endian = nxt_st.ctrl_one[BAC_BIT_ENDIAN];
        // float only when not driving and in standby or bus release
        nxt_st.strobe_float = ~nxt_st.ctrl_one[BAC_BIT_STROBE]
            & (standby | bus_release);
        nxt_st.a0_en = a0_en_d;
        nxt_st.a0_beats = a0_beats_d;
        nxt_st.a5_en = a5_en_d;
        nxt_st.a5_beats = a5_beats_d;
        nxt_st.a6_en = a6_en_d;
        nxt_st.a6_beats = a6_beats_d;
        // reserved codes fall back to normal memory
        case (memtype)
            BAC_MT_A3_DRAM: begin
                nxt_st.a2_dram = 1'b0;
                nxt_st.a3_dram = 1'b1;
            end
            BAC_MT_BOTH_DRAM: begin
                nxt_st.a2_dram = 1'b1;
                nxt_st.a3_dram = 1'b1;
            end
            default: begin
                nxt_st.a2_dram = 1'b0;
                nxt_st.a3_dram = 1'b0;
            end
        endcase
        nxt_st.a5_card = nxt_st.ctrl_one[BAC_BIT_A5_CARD];
        nxt_st.a6_card = nxt_st.ctrl_one[BAC_BIT_A6_CARD];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.strap_pending <= 1'b1;
            st_ff.ctrl_one <= BAC_CTRL_ONE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign little_endian = st_ff.little_endian;
    assign strobe_float = st_ff.strobe_float;
    assign area0_burst_en = st_ff.a0_en;
    assign area0_burst_beats = st_ff.a0_beats;
    assign area5_burst_en = st_ff.a5_en;
    assign area5_burst_beats = st_ff.a5_beats;
    assign area6_burst_en = st_ff.a6_en;
    assign area6_burst_beats = st_ff.a6_beats;
    assign area2_dram = st_ff.a2_dram;
    assign area3_dram = st_ff.a3_dram;
    assign area5_card_space = st_ff.a5_card;
    assign area6_card_space = st_ff.a6_card;
endmodule : bac_top

// >>> bench/bac_top_assertions.sv
// Purpose: port checks of the area control register
// Assumes: offset 0 is the only mapped address
// Notes: bound into every bac_top
`timescale 1ns/100ps
module bac_top_assertions (
    // watched ports
    input wire logic mclk, rst_n, manual_reset, standby, bus_release, reg_wr, reg_rd,
    input wire logic [bac_pkg::BAC_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata, reg_rdata,
    input wire logic little_endian, strobe_float, area2_dram, area3_dram,
    input wire logic area5_card_space, area6_card_space,
    input wire logic [4:0] area0_burst_beats
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire w0 = reg_wr && reg_addr == 4'h0;
    wire r0 = reg_rd && reg_addr == 4'h0;
    // bit 11 is the strap, not write data, so only writable bits are compared
    property p_rb;
        w0 ##1 r0 |=> (reg_rdata & 16'h17ff) == ($past(reg_wdata, 2) & 16'h17ff);
    endproperty
    a_rb: assert property (p_rb) else $error("readback wrong");
    property p_rz; r0 |=> reg_rdata[15:13] == 3'h0 && reg_rdata[11] == little_endian; endproperty
    a_rz: assert property (p_rz) else $error("reserved or strap bits wrong");
    property p_le; $past(rst_n) |=> $stable(little_endian); endproperty
    a_le: assert property (p_le) else $error("byte order moved");
    property p_sf; w0 ##1 (standby || bus_release) |=> strobe_float == !$past(reg_wdata[12], 2);
    endproperty
    a_sf: assert property (p_sf) else $error("strobe float wrong");
    property p_mr; manual_reset && !reg_wr |=> $stable(area5_card_space) && $stable(area2_dram);
    endproperty
    a_mr: assert property (p_mr) else $error("settings moved");
    property p_b0; w0 && reg_wdata[10:9] == 2'h3 |=> area0_burst_beats == 5'h10; endproperty
    a_b0: assert property (p_b0) else $error("area0 beats wrong");
    property p_mt; w0 && reg_wdata[4:2] == 3'h4 |=> area3_dram && !area2_dram; endproperty
    a_mt: assert property (p_mt) else $error("memory type wrong");
    property p_cs; w0 |=> {area5_card_space, area6_card_space} == $past(reg_wdata[1:0]); endproperty
    a_cs: assert property (p_cs) else $error("card space wrong");
    c_rb: cover property (w0 ##1 r0);
    c_mr: cover property (manual_reset && w0);
    c_sf: cover property (standby && strobe_float);
endmodule : bac_top_assertions
bind bac_top bac_top_assertions u_chk (.*);

// >>> bench/bac_top_tb.sv
// Purpose: self-checking bench for the area control register
// Assumes: strap taken on the first edge after reset release
// Notes: reserved memory type codes never written
`timescale 1ns/100ps
module bac_top_tb;
    logic mclk = 1'b0, rst_n, byte_order_mode_pin, manual_reset, standby, bus_release;
    logic reg_wr, reg_rd, little_endian, strobe_float, area0_burst_en, area5_burst_en;
    logic area6_burst_en, area2_dram, area3_dram, area5_card_space, area6_card_space;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, m, s = 16'h40cb;
    logic [4:0] area0_burst_beats, area5_burst_beats, area6_burst_beats;
    logic [4:0] bl [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
    logic [2:0] mt [3] = '{3'h0, 3'h4, 3'h5};
    int fail_count = 0, checks_done = 0;
    bac_top u_dut (.*);
    initial forever #5 mclk = ~mclk;
    function logic [15:0] lf(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lf
    task chk(input logic [23:0] seen, input logic [23:0] exp, input string nm);
        checks_done++;
        if (seen !== exp) $display("Error %s expected %h seen %h", nm, exp, seen);
        fail_count += int'(seen !== exp);
    endtask : chk
    // write wa, then read ra with no gap
    task xfer(input logic [3:0] wa, input logic [15:0] d, input logic [3:0] ra);
        reg_wr <= 1'b1;
        reg_addr <= wa;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= ra;
        if (wa == 4'h0) m = (d & 16'h17ff) | (m & 16'h0800);
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, (ra == 4'h0) ? m : 16'h0, "rdata");
        chk({area0_burst_beats, area5_burst_beats, area6_burst_beats,
            area0_burst_en, area5_burst_en, area6_burst_en, area2_dram, area3_dram,
            area5_card_space, area6_card_space, strobe_float, little_endian},
            {bl[m[10:9]], bl[m[8:7]], bl[m[6:5]], |m[10:9], |m[8:7], |m[6:5], m[4:2] == 3'h5,
            m[4], m[1], m[0], !m[12] && (standby || bus_release), m[11]}, "settings");
        @(posedge mclk);
    endtask : xfer
    // unmapped write must not disturb the reset value read next
    task do_reset(input logic p);
        byte_order_mode_pin <= p;
        rst_n <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        m = {4'h0, p, 11'h0};
        xfer(4'h9, 16'hffff, 4'h0);
    endtask : do_reset
    task give_verdict();
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        {rst_n, byte_order_mode_pin, manual_reset, standby, bus_release, reg_wr, reg_rd} = 7'h0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0;
        do_reset(1'b1);
        for (int i = 0; i < 48; i++) begin
            s = lf(s);
            {standby, bus_release, manual_reset, byte_order_mode_pin} <= s[3:0];
            // bus widths sit outside this block, so any burst code pairs legally
            xfer(4'h0, {s[15:5], mt[i % 3], s[1:0]}, 4'h0);
            xfer(4'h9, ~s, 4'h9);
        end
        do_reset(1'b0);
        give_verdict();
    end
endmodule : bac_top_tb
